// ===== core/irq_ctrl.sv
// external irq front end with vector and priority selection
//
// Implementation choices: the register offsets and the strobed register port.
`include "irq_defs.svh"

module irq_ctrl (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              hw_standby_i,
    input  wire logic              sw_standby_i,
    input  wire irq_pkg::reg_req_t bus_i,
    output      logic [7:0]        rdata_o,
    input  wire logic              nmi_pin_i,
    input  wire logic [5:0]        line_pin_i,
    input  wire irq_pkg::int_src_t int_src_i,
    input  wire logic [5:0]        dma_route_i,
    input  wire irq_pkg::cpu_mask_t cpu_mask_i,
    input  wire logic              ack_i,
    output      irq_pkg::vec_out_t vec_o,
    output      logic [5:0]        dma_start_o,
    output      logic              wake_o
);
    logic [7:0]  enable_r;
    logic [7:0]  sense_r;
    logic [5:0]  status_r;
    logic [5:0]  status_nxt;
    logic [7:0]  prio_a_r;
    logic [7:0]  prio_b_r;
    logic [7:0]  sysctl_r;
    logic [5:0]  line_s1_r;
    logic [5:0]  line_s2_r;
    logic [5:0]  line_d_r;
    logic        nmi_s1_r;
    logic        nmi_s2_r;
    logic        nmi_d_r;
    logic        nmi_pend_r;
    logic        nmi_edge;
    logic [5:0]  line_set;
    logic [13:0] raw;
    logic [13:0] lvl;
    logic [13:0] cand;
    logic [13:0] hi;
    logic [3:0]  sel_idx;
    logic        wr;
    logic        ack_nmi;
    logic [5:0]  ack_line;
    irq_pkg::vec_out_t vec_nxt;
    logic [7:0]  rdata_nxt;

    // fixed vector per source index; only listed numbers exist
    function automatic logic [5:0] vec_of(input logic [3:0] idx);
        logic [5:0] v;
        v = `VEC_LINE0;
        case (idx)
            4'h0, 4'h1, 4'h2, 4'h3, 4'h4, 4'h5: v = `VEC_LINE0 + {2'b00, idx}; // RL10
            4'h6: v = `VEC_WDT; // RL20
            4'h7: v = `VEC_REFRESH; // RL20
            4'h8, 4'h9, 4'ha: v = `VEC_T0 + {2'b00, idx - 4'h8}; // RL21
            4'hb, 4'hc, 4'hd: v = `VEC_T1 + {2'b00, idx - 4'hb}; // RL22
            default: v = `VEC_LINE0; // RL27
        endcase
        return v;
    endfunction : vec_of

    // lowest set index wins, which is the smaller vector
    function automatic logic [3:0] lowest(input logic [13:0] v);
        logic [3:0] r;
        r = 4'h0;
        for (int k = 13; k >= 0; k--) begin
            if (v[k]) begin
                r = k[3:0];
            end
        end
        return r;
    endfunction : lowest

    assign wr = bus_i.we;

    // two-stage synchronisers; stage one feeds stage two only
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            line_s1_r <= 6'h3f;
            line_s2_r <= 6'h3f;
            line_d_r  <= 6'h3f;
            nmi_s1_r  <= 1'b0;
            nmi_s2_r  <= 1'b0;
            nmi_d_r   <= 1'b0;
        end else begin
            line_s1_r <= line_pin_i; // RL11 RL26
            line_s2_r <= line_s1_r; // RL26
            line_d_r  <= line_s2_r;
            nmi_s1_r  <= nmi_pin_i; // RL26
            nmi_s2_r  <= nmi_s1_r;
            nmi_d_r   <= nmi_s2_r;
        end
    end

    // level or falling-edge set condition per line
    always_comb begin
        for (int n = 0; n < `NUM_LINES; n++) begin
            if (sense_r[n]) begin
                line_set[n] = line_d_r[n] & ~line_s2_r[n]; // RL5 RL23
            end else begin
                line_set[n] = ~line_s2_r[n]; // RL5 RL23
            end
        end
    end

    // edge select 1 means rising edge
    assign nmi_edge = sysctl_r[`SYS_NMI_EDGE] ? (nmi_s2_r & ~nmi_d_r)
                                             : (~nmi_s2_r & nmi_d_r); // RL8

    // acceptance decode of the presented vector
    assign ack_nmi = ack_i & vec_o.req & (vec_o.vec == `VEC_NMI);
    always_comb begin
        for (int n = 0; n < `NUM_LINES; n++) begin
            ack_line[n] = ack_i & vec_o.req & ~ack_nmi & sense_r[n]
                          & (vec_o.vec == vec_of(n[3:0]));
        end
    end

    // control registers; hardware standby clears like reset
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            enable_r <= `RST_ENABLE; // RL1
            sense_r  <= `RST_SENSE; // RL4
            prio_a_r <= `RST_PRIO; // RL17
            prio_b_r <= `RST_PRIO;
            sysctl_r <= `RST_SYSCTL;
        end else if (hw_standby_i) begin
            enable_r <= `RST_ENABLE; // RL1
            sense_r  <= `RST_SENSE; // RL4
            prio_a_r <= `RST_PRIO;
            prio_b_r <= `RST_PRIO;
            sysctl_r <= `RST_SYSCTL;
        end else if (wr) begin
            case (bus_i.addr)
                `ADDR_ENABLE: enable_r <= bus_i.wdata; // RL3
                `ADDR_SENSE:  sense_r  <= bus_i.wdata; // RL6
                `ADDR_PRIO_A: prio_a_r <= bus_i.wdata; // RL18
                `ADDR_PRIO_B: prio_b_r <= bus_i.wdata; // RL18
                `ADDR_SYSCTL: sysctl_r <= bus_i.wdata;
                default: ;
            endcase
        end
    end

    // status flags: writing 0 clears, a new set in the same cycle wins
    always_comb begin
        status_nxt = status_r;
        if (wr && bus_i.addr == `ADDR_STATUS) begin
            status_nxt = status_r & bus_i.wdata[5:0]; // RL14
        end
        status_nxt = (status_nxt & ~ack_line) | line_set; // RL14 RL23
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            status_r <= `RST_STATUS;
        end else if (hw_standby_i) begin
            status_r <= `RST_STATUS;
        end else begin
            status_r <= status_nxt;
        end
    end

    // non-maskable pending, cleared by acceptance or hardware standby
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            nmi_pend_r <= 1'b0;
        end else if (hw_standby_i) begin
            nmi_pend_r <= 1'b0;
        end else begin
            nmi_pend_r <= nmi_edge | (nmi_pend_r & ~ack_nmi);
        end
    end

    // requests and their priority levels in vector order
    always_comb begin
        raw[5:0]   = status_r & enable_r[5:0]; // RL2
        raw[7:6]   = {int_src_i.refresh, int_src_i.wdt}; // RL15
        raw[13:8]  = {int_src_i.t1_ovf, int_src_i.t1_b, int_src_i.t1_a,
                      int_src_i.t0_ovf, int_src_i.t0_b, int_src_i.t0_a}
                     & ~dma_route_i; // RL16
        lvl[0]     = prio_a_r[`PRIO_LINE0]; // RL13
        lvl[1]     = prio_a_r[`PRIO_LINE1]; // RL13
        lvl[3:2]   = {2{prio_a_r[`PRIO_LINE23]}}; // RL13
        lvl[5:4]   = {2{prio_a_r[`PRIO_LINE45]}}; // RL13
        lvl[7:6]   = {2{prio_a_r[`PRIO_WDT_REF]}}; // RL20
        lvl[10:8]  = {3{prio_a_r[`PRIO_T0]}}; // RL21
        lvl[13:11] = {3{prio_a_r[`PRIO_T1]}}; // RL22
    end

    // three-level masking; level 1 passes an i-only mask when ue is 0
    assign cand = raw & ({14{~cpu_mask_i.i}}
                  | ({14{~sysctl_r[`SYS_UE] & ~cpu_mask_i.secondary_mask_bit}} & lvl)); // RL25
    assign hi   = cand & lvl;
    assign sel_idx = (|hi) ? lowest(hi) : lowest(cand); // RL17 RL24

    // non-maskable overrides everything and needs no mask check
    always_comb begin
        vec_nxt = '0;
        if (nmi_pend_r) begin
            vec_nxt.req = 1'b1; // RL7
            vec_nxt.vec = `VEC_NMI; // RL9
        end else if (|cand) begin
            vec_nxt.req = 1'b1;
            vec_nxt.vec = vec_of(sel_idx); // RL27
        end
        vec_nxt.addr = {vec_nxt.vec, 2'b00}; // RL19
    end

    // presented vector; one cycle behind the pending state
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            vec_o <= '0;
        end else if (hw_standby_i) begin
            vec_o <= '0;
        end else begin
            vec_o <= vec_nxt;
        end
    end

    // dma start bypasses the controller and the cpu masks
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            dma_start_o <= 6'h00;
        end else begin
            dma_start_o <= {int_src_i.t1_ovf, int_src_i.t1_b, int_src_i.t1_a,
                            int_src_i.t0_ovf, int_src_i.t0_b, int_src_i.t0_a}
                           & dma_route_i; // RL16
        end
    end

    // software standby exit; only a subset of sources may wake
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            wake_o <= 1'b0;
        end else begin
            wake_o <= sw_standby_i & (nmi_pend_r
                      | (|raw[`WAKE_LINES-1:0])); // RL12
        end
    end

    // read mux; unmapped addresses and reserved status bits read 0
    always_comb begin
        rdata_nxt = 8'h00;
        case (bus_i.addr)
            `ADDR_ENABLE: rdata_nxt = enable_r; // RL3
            `ADDR_SENSE:  rdata_nxt = sense_r; // RL6
            `ADDR_STATUS: rdata_nxt = {2'b00, status_r}; // RL14
            `ADDR_PRIO_A: rdata_nxt = prio_a_r;
            `ADDR_PRIO_B: rdata_nxt = prio_b_r;
            `ADDR_SYSCTL: rdata_nxt = sysctl_r;
            default:      rdata_nxt = 8'h00;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            rdata_o <= 8'h00;
        end else if (bus_i.re) begin
            rdata_o <= rdata_nxt;
        end else begin
            rdata_o <= 8'h00;
        end
    end
endmodule : irq_ctrl

// ===== core/irq_defs.svh
// register offsets, field positions, reset values and vector numbers of the irq front end
// Behaviour
// RL1: enable register clears to zero on reset and hardware standby.
// RL2: enable bits 5..0 gate their request line; 0 disables, 1 enables.
// RL3: enable bits 7 and 6 are plain storage with no effect.
// RL4: sense-select register clears to zero on reset and hardware standby.
// RL5: sense bit 0 means low level requests; 1 means falling edge requests.
// RL6: sense bits 7 and 6 are plain storage, no effect on sensing.
// RL7: non-maskable request has top priority and ignores both cpu mask bits.
// RL8: edge select bit picks rising or falling edge on the non-maskable pin.
// RL9: accepted non-maskable request presents vector 7.
// RL10: external lines 0..5 map in order to vectors 12..17.
// RL11: detection uses the pin value whatever the pin direction.
// RL12: only non-maskable and lines 0..2 wake from software standby.
// RL13: line priority from first priority bits 7,6,5,5,4,4.
// RL14: status flags show pending lines; software clears each by writing 0.
// RL15: internal requests arrive with own flags and enables; priority from registers.
// RL16: timer request routed to dma never reaches arbitration, masks ignored.
// RL17: default order is smaller vector wins, in force after reset.
// RL18: all sources but non-maskable adjustable via the priority registers.
// RL19: vector address is four times the vector number.
// RL20: watchdog vector 20, refresh vector 21, both under priority bit 3.
// RL21: timer 0 a, b, overflow use vectors 24..26 under bit 2.
// RL22: timer 1 a, b, overflow use vectors 28..30 under bit 1.
// RL23: flag sets while line low in level mode, on falling edge in edge mode.
// RL24: equal priority settings fall back to default vector order.
// RL25: with global mask set only the non-maskable request is accepted; code passes level-1 sources when ue is 0 and secondary bit clear.
// RL26: pins pass a two-stage synchroniser before edge detection.
// RL27: reserved vectors 18,19,22,23,27,31 are never produced.
`ifndef IRQ_DEFS_SVH
`define IRQ_DEFS_SVH

`define ADDR_ENABLE   8'h00
`define ADDR_SENSE    8'h01
`define ADDR_STATUS   8'h02
`define ADDR_PRIO_A   8'h03
`define ADDR_PRIO_B   8'h04
`define ADDR_SYSCTL   8'h05

`define RST_ENABLE    8'h00
`define RST_SENSE     8'h00
`define RST_STATUS    6'h00
`define RST_PRIO      8'h00
`define RST_SYSCTL    8'h02

`define SYS_NMI_EDGE  0
`define SYS_UE        1

`define NUM_LINES     6
`define NUM_SRC       14
`define WAKE_LINES    3

`define VEC_NMI       6'h07
`define VEC_LINE0     6'h0c
`define VEC_WDT       6'h14
`define VEC_REFRESH   6'h15
`define VEC_T0        6'h18
`define VEC_T1        6'h1c

`define PRIO_LINE0    7
`define PRIO_LINE1    6
`define PRIO_LINE23   5
`define PRIO_LINE45   4
`define PRIO_WDT_REF  3
`define PRIO_T0       2
`define PRIO_T1       1

`endif

// ===== core/irq_pkg.sv
// types shared by the irq front end and its surroundings
package irq_pkg;
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       we;
        logic       re;
    } reg_req_t;

    // order follows ascending vector number
    typedef struct packed {
        logic t1_ovf;
        logic t1_b;
        logic t1_a;
        logic t0_ovf;
        logic t0_b;
        logic t0_a;
        logic refresh;
        logic wdt;
    } int_src_t;

    typedef struct packed {
        logic i;
        logic secondary_mask_bit;
    } cpu_mask_t;

    typedef struct packed {
        logic       req;
        logic [5:0] vec;
        logic [7:0] addr;
    } vec_out_t;
endpackage : irq_pkg

// ===== dv/cpu_model.sv
// behavioural cpu exception side: acknowledges each presented vector
module cpu_model (
    input  wire logic              mclk_i,
    input  wire logic              rst_n_i,
    input  wire logic              en_i,
    input  wire logic [3:0]        delay_i,
    input  wire irq_pkg::vec_out_t vec_i,
    output      logic              ack_o
);
    logic [3:0] wait_r;

    // one-cycle ack after a delay; the extra count skips the stale vector after an ack
    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            ack_o  <= 1'b0;
            wait_r <= 4'h0;
        end else if (ack_o || !vec_i.req || !en_i) begin
            ack_o  <= 1'b0;
            wait_r <= 4'h0;
        end else if (wait_r > delay_i) begin
            ack_o <= 1'b1;
        end else begin
            wait_r <= wait_r + 4'h1;
        end
    end
endmodule : cpu_model

// ===== dv/external_irq_and_vector_priority_tb_top.sv
// testbench for the irq front end: registers, pins, priority, masks, standby
`include "irq_defs.svh"

module external_irq_and_vector_priority_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic               clk = 1'b0, rst_n = 1'b0, hws = 1'b0, sws = 1'b0, nmi = 1'b0;
    logic               cpu_en = 1'b0, ack, wake;
    irq_pkg::reg_req_t  bus = '0;
    irq_pkg::int_src_t  src = '0;
    irq_pkg::cpu_mask_t mask = '0;
    irq_pkg::vec_out_t  vec;
    logic [5:0]         pins = 6'h3f, route = 6'h00, dma;
    logic [3:0]         cpu_dly = 4'h0;
    logic [7:0]         rdata;
    logic [7:0]         rst_tab [7] = '{8'h00, 8'h00, 8'h00, 8'h00, 8'h00, `RST_SYSCTL, 8'h00};
    logic [5:0]         src_vec [8] = '{6'h14, 6'h15, 6'h18, 6'h19, 6'h1a, 6'h1c, 6'h1d, 6'h1e};
    int                 error_cnt = 0, n_compared = 0;

    irq_ctrl uut (.mclk_i(clk), .rst_n_i(rst_n), .hw_standby_i(hws), .sw_standby_i(sws),
        .bus_i(bus), .rdata_o(rdata), .nmi_pin_i(nmi), .line_pin_i(pins), .int_src_i(src),
        .dma_route_i(route), .cpu_mask_i(mask), .ack_i(ack), .vec_o(vec),
        .dma_start_o(dma), .wake_o(wake));
    cpu_model cpu (.mclk_i(clk), .rst_n_i(rst_n), .en_i(cpu_en), .delay_i(cpu_dly),
        .vec_i(vec), .ack_o(ack));

    // free-running 125 MHz clock
    initial begin
        forever #4 clk = ~clk;
    end

    task results;
        if (error_cnt == 0 && n_compared > 0) $display("DONE - PASS");
        else $display("DONE - FAIL");
        $finish;
    endtask : results

    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        n_compared++;
        if (seen !== exp) begin
            error_cnt++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk

    // bus cycles: strobes launched on the edge, read data taken mid-cycle
    task wr(input logic [7:0] a, input logic [7:0] d);
        @(posedge clk) bus <= '{a, d, 1'b1, 1'b0};
        @(posedge clk) bus.we <= 1'b0;
    endtask : wr

    task rd(input logic [7:0] a, input logic [7:0] e);
        @(posedge clk) bus <= '{a, 8'h00, 1'b0, 1'b1};
        @(posedge clk) bus.re <= 1'b0;
        @(negedge clk) chk("rdata", rdata, e);
    endtask : rd

    task idle(input int n);
        repeat (n) @(posedge clk);
        @(negedge clk);
    endtask : idle

    // bounded wait for a request, then vector and address together
    task expv(input logic [5:0] v);
        int k;
        for (k = 0; k < 30; k++) begin
            @(negedge clk);
            if (vec.req === 1'b1) break;
        end
        if (k == 30) begin
            error_cnt++;
            results();
        end else begin
            chk("vector", {vec.vec, vec.addr}, {v, v, 2'b00});
        end
    endtask : expv

    // release pins long enough for the synchroniser, then clear flags
    task flush;
        @(posedge clk) pins <= 6'h3f;
        idle(6);
        wr(`ADDR_STATUS, 8'h00);
        idle(3);
    endtask : flush

    initial begin
        repeat (12) @(posedge clk);
        rst_n <= 1'b1;
        for (int a = 0; a < 7; a++) rd(a[7:0], rst_tab[a]);
        wr(`ADDR_ENABLE, 8'hc0);
        wr(`ADDR_SENSE, 8'hc0);
        rd(`ADDR_ENABLE, 8'hc0);
        rd(`ADDR_SENSE, 8'hc0);
        @(posedge clk) pins <= 6'h3e;
        idle(6);
        chk("req", vec.req, 1'b0);
        rd(`ADDR_STATUS, 8'h01);
        @(posedge clk) cpu_en <= 1'b1;
        wr(`ADDR_ENABLE, 8'h3f);
        expv(`VEC_LINE0);
        flush;
        rd(`ADDR_STATUS, 8'h00);
        for (int n = 0; n < 6; n++) begin
            @(posedge clk) pins <= ~(6'h01 << n);
            expv(`VEC_LINE0 + n[5:0]);
            flush;
        end
        // edge mode: one falling edge, one flag, cleared by the ack
        wr(`ADDR_SENSE, 8'h01);
        pins <= 6'h3e;
        expv(`VEC_LINE0);
        idle(8);
        chk("req", vec.req, 1'b0);
        rd(`ADDR_STATUS, 8'h00);
        wr(`ADDR_SENSE, 8'h00);
        flush;
        // priority: lines 0 and 5, then the watchdog raised above both
        @(posedge clk) cpu_en <= 1'b0;
        pins <= 6'h1e;
        expv(`VEC_LINE0);
        wr(`ADDR_PRIO_A, 8'h10);
        idle(3);
        chk("vec", vec.vec, 6'h11);
        wr(`ADDR_PRIO_A, 8'h08);
        src <= 8'h01;
        idle(3);
        chk("vec", vec.vec, `VEC_WDT);
        wr(`ADDR_PRIO_A, 8'h00);
        src <= 8'h00;
        wr(`ADDR_PRIO_B, 8'h5a);
        rd(`ADDR_PRIO_B, 8'h5a);
        flush;
        for (int s = 0; s < 8; s++) begin
            @(posedge clk) src <= 8'h01 << s;
            expv(src_vec[s]);
            @(posedge clk) src <= 8'h00;
            idle(3);
        end
        // routed timer request goes to the dma side only
        @(posedge clk) route <= 6'h01;
        src <= 8'h04;
        idle(4);
        chk("req", vec.req, 1'b0);
        chk("dma", dma, 6'h01);
        // masked line pending; rising pin ignored in falling-edge mode
        @(posedge clk) src <= 8'h00;
        route <= 6'h00;
        mask <= '{1'b1, 1'b1};
        pins <= 6'h3d;
        nmi <= 1'b1;
        cpu_en <= 1'b1;
        cpu_dly <= 4'h3;
        idle(8);
        chk("req", vec.req, 1'b0);
        @(posedge clk) nmi <= 1'b0;
        expv(`VEC_NMI);
        idle(10);
        wr(`ADDR_SYSCTL, 8'h03);
        nmi <= 1'b1;
        expv(`VEC_NMI);
        idle(10);
        chk("req", vec.req, 1'b0);
        // ue cleared: global mask with secondary bit clear passes level-1 only
        wr(`ADDR_SYSCTL, 8'h01);
        mask <= '{1'b1, 1'b0};
        idle(4);
        chk("req", vec.req, 1'b0);
        wr(`ADDR_PRIO_A, 8'h40);
        expv(`VEC_LINE0 + 6'h01);
        wr(`ADDR_PRIO_A, 8'h00);
        @(posedge clk) mask <= '0;
        expv(`VEC_LINE0 + 6'h01);
        flush;
        // wake only from lines 0..2
        @(posedge clk) sws <= 1'b1;
        pins <= 6'h37;
        idle(8);
        chk("wake", wake, 1'b0);
        @(posedge clk) pins <= 6'h36;
        idle(8);
        chk("wake", wake, 1'b1);
        @(posedge clk) sws <= 1'b0;
        pins <= 6'h3f;
        idle(6);
        wr(`ADDR_SENSE, 8'hc0);
        hws <= 1'b1;
        @(posedge clk) hws <= 1'b0;
        rd(`ADDR_ENABLE, 8'h00);
        rd(`ADDR_SENSE, 8'h00);
        results();
    end
endmodule : external_irq_and_vector_priority_tb_top

// ===== dv/irq_ctrl_monitor.sv
// port-level assertion checker for the irq front end
`include "irq_defs.svh"

module irq_ctrl_monitor (
    input wire logic               mclk_i,
    input wire logic               rst_n_i,
    input wire logic               hw_standby_i,
    input wire logic               sw_standby_i,
    input wire irq_pkg::reg_req_t  bus_i,
    input wire logic [7:0]         rdata_o,
    input wire logic               nmi_pin_i,
    input wire logic [5:0]         line_pin_i,
    input wire irq_pkg::int_src_t  int_src_i,
    input wire logic [5:0]         dma_route_i,
    input wire irq_pkg::cpu_mask_t cpu_mask_i,
    input wire logic               ack_i,
    input wire irq_pkg::vec_out_t  vec_o,
    input wire logic [5:0]         dma_start_o,
    input wire logic               wake_o
);
    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    property p_addr;
        vec_o.req |-> vec_o.addr == {vec_o.vec, 2'b00};
    endproperty
    a_addr: assert property (p_addr) else $error("vector address not four times vector");
    property p_rsvd;
        vec_o.req |-> !(vec_o.vec inside {6'h12, 6'h13, 6'h16, 6'h17, 6'h1b, 6'h1f});
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved vector presented");
    property p_legal;
        vec_o.req |-> vec_o.vec inside {6'h07, [6'h0c:6'h11], 6'h14, 6'h15, [6'h18:6'h1a], [6'h1c:6'h1e]};
    endproperty
    a_legal: assert property (p_legal) else $error("vector outside source table");
    property p_hws;
        hw_standby_i |=> !vec_o.req;
    endproperty
    a_hws: assert property (p_hws) else $error("request survives hardware standby");
    property p_dma;
        dma_start_o == ($past(int_src_i[7:2]) & $past(dma_route_i));
    endproperty
    a_dma: assert property (p_dma) else $error("dma start does not follow routed requests");
    property p_stat;
        $past(bus_i.re) && $past(bus_i.addr) == `ADDR_STATUS |-> rdata_o[7:6] == 2'b00;
    endproperty
    a_stat: assert property (p_stat) else $error("status reserved bits read nonzero");
    property p_wake;
        wake_o |-> $past(sw_standby_i);
    endproperty
    a_wake: assert property (p_wake) else $error("wake outside software standby");
    property p_mask;
        $past(cpu_mask_i.i) && $past(cpu_mask_i.secondary_mask_bit) && vec_o.req
            |-> vec_o.vec == `VEC_NMI;
    endproperty
    a_mask: assert property (p_mask) else $error("masked source presented");
endmodule : irq_ctrl_monitor

bind irq_ctrl irq_ctrl_monitor mon (.mclk_i(mclk_i), .rst_n_i(rst_n_i),
    .hw_standby_i(hw_standby_i), .sw_standby_i(sw_standby_i), .bus_i(bus_i),
    .rdata_o(rdata_o), .nmi_pin_i(nmi_pin_i), .line_pin_i(line_pin_i),
    .int_src_i(int_src_i), .dma_route_i(dma_route_i), .cpu_mask_i(cpu_mask_i),
    .ack_i(ack_i), .vec_o(vec_o), .dma_start_o(dma_start_o), .wake_o(wake_o));
